// ==== design/cod_regs.vh ====
// Constants for the opcode decoder: opcode fields, mode codes, cycle counts.
// Included by the decoder; holds definitions only.
`ifndef COD_REGS_VH
`define COD_REGS_VH
// Flag positions in the condition code vector
`define COD_H 4
`define COD_I 3
`define COD_N 2
`define COD_Z 1
`define COD_C 0
`define COD_CCR_RST 5'h08
// High nibble families
`define COD_HI_BTB 4'h0
`define COD_HI_REL 4'h2
`define COD_HI_DIRRMW 4'h3
`define COD_HI_INHA 4'h4
`define COD_HI_INHX 4'h5
`define COD_HI_IX1RMW 4'h6
`define COD_HI_IXRMW 4'h7
`define COD_HI_IMM 4'ha
`define COD_HI_DIR 4'hb
`define COD_HI_EXT 4'hc
`define COD_HI_IX2 4'hd
`define COD_HI_IX1 4'he
`define COD_HI_IX 4'hf
// Low nibble operations
`define COD_LO_COMPARE 4'h1
`define COD_LO_BORROW_SUB 4'h2
`define COD_LO_PRODUCT 4'h2
`define COD_LO_BIT 4'h5
`define COD_LO_XOR 4'h8
`define COD_LO_ADC 4'h9
`define COD_LO_ROTATE 4'h9
`define COD_LO_PROBE 4'hd
// Addressing mode codes
`define COD_M_IMM 4'h0
`define COD_M_DIR 4'h1
`define COD_M_EXT 4'h2
`define COD_M_IX 4'h3
`define COD_M_IX1 4'h4
`define COD_M_IX2 4'h5
`define COD_M_INHA 4'h6
`define COD_M_INHX 4'h7
`define COD_M_REL 4'h8
`define COD_M_BTB 4'h9
`define COD_M_INH 4'ha
`define COD_M_NONE 4'hf
// Cycle counts
`define COD_CYC_PRODUCT 4'hb
`define COD_CYC_REL 4'h3
`define COD_CYC_BTB 4'h5
`endif

// ==== design/cod_decoder.v ====
// Opcode decoder and execute step for an 8-bit accumulator/index core.
// Assumes the sequencer presents opcode, registers, flags and the fetched
// operand together with a one-cycle request; answers one cycle later.
//
// Functional notes
// RULE_01: Modify operations read operand, alter it, write it back in place.
// RULE_02: The nonwriting probe sets flags only and never writes back.
// RULE_03: Product multiplies index by accum into index:accum, 11 cycles.
// RULE_04: Carry-add decodes A9..D9, six modes, lengths 2,2,3,1,2,3 bytes.
// RULE_05: Borrow subtract decodes A2..D2 with accumulator arithmetic timing.
// RULE_06: Accumulator xor decodes A8..D8 taking 2,3,4,3,4,5 cycles.
// RULE_07: Compare subtracts operand from accum for flags, accum unchanged.
// RULE_08: Mask test ANDs accum with operand for flags, result discarded.
// RULE_09: Opcode 24 branch no carry or alias, 25 carry set or alias.
// RULE_10: Opcode 22 branches if higher, 23 if lower or same.
// RULE_11: Opcode 2C branches on mask clear, 2D on mask set.
// RULE_12: Opcode 2E branches on interrupt pin low, 2F on high.
// RULE_13: Opcode 28 branches on half carry clear, 29 on set.
// RULE_14: Product clears half carry and carry, keeps other flags.
// RULE_15: Relative branch redirects only when condition holds; two bytes.
// RULE_16: Probe decodes 4D,5D,3D,7D,6D taking 3,3,4,4,5 cycles.
// RULE_17: Rotate left decodes 49,59,39,79,69 taking 3,3,5,5,6 cycles.
// RULE_18: Bit test branch opcode 0n, 3 bytes, 5 cycles, bit into carry.
`timescale 1ns/100ps
`default_nettype none
`include "cod_regs.vh"

module cod_decoder (
   // Clock and reset
   input wire ref_clk,
   input wire rst_b,
   // Request from the sequencer
   input wire dec_valid,
   input wire [7:0] opcode,
   input wire [7:0] accum,
   input wire [7:0] index,
   input wire [7:0] operand,
   input wire [4:0] ccr_in,
   // Interrupt pin, asynchronous
   input wire irq_pin,
   // Decode answer
   output reg dec_done,
   output reg known,
   output reg [3:0] mode,
   output reg [1:0] instr_bytes,
   output reg [3:0] instr_cycles,
   output reg write_back,
   output reg branch_taken,
   // Execute results
   output reg [7:0] accum_out,
   output reg [7:0] index_out,
   output reg [7:0] result_out,
   output reg [4:0] ccr_out
);

   reg irq_s1;
   reg irq_s2;
   reg irq_s3;
   reg irq_level;
   reg next_known;
   reg [3:0] next_mode;
   reg [1:0] next_bytes;
   reg [3:0] next_cycles;
   reg next_wb;
   reg next_taken;
   reg [7:0] next_accum;
   reg [7:0] next_index;
   reg [7:0] next_result;
   reg [4:0] next_ccr;
   reg base_cond;
   reg [8:0] sum9;
   reg [4:0] low5;
   reg [15:0] prod;
   reg tbit;
   wire [3:0] hi = opcode[7:4];
   wire [3:0] lo = opcode[3:0];
   wire c_in = ccr_in[`COD_C];

   // Pin synchroniser; level moves only when stages two and three agree
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         irq_s1 <= 1'b1;
         irq_s2 <= 1'b1;
         irq_s3 <= 1'b1;
         irq_level <= 1'b1;
      end else begin
         irq_s1 <= irq_pin;
         irq_s2 <= irq_s1;
         irq_s3 <= irq_s2;
         if (irq_s2 == irq_s3)
            irq_level <= irq_s3;
      end
   end

   // Branch condition table; odd opcodes invert the even test
   always @* begin
      case (opcode[3:1])
         3'h0: base_cond = 1'b1;
         3'h1: base_cond = ~(ccr_in[`COD_C] | ccr_in[`COD_Z]); // [RULE_10]
         3'h2: base_cond = ~ccr_in[`COD_C]; // [RULE_09]
         3'h3: base_cond = ~ccr_in[`COD_Z];
         3'h4: base_cond = ~ccr_in[`COD_H]; // [RULE_13]
         3'h5: base_cond = ~ccr_in[`COD_N];
         3'h6: base_cond = ~ccr_in[`COD_I]; // [RULE_11]
         3'h7: base_cond = ~irq_level; // [RULE_12]
         default: base_cond = 1'b0;
      endcase
   end

   // Decode and execute in one pass
   always @* begin
      next_known = 1'b1;
      next_mode = `COD_M_NONE;
      next_bytes = 2'h0;
      next_cycles = 4'h0;
      next_wb = 1'b0;
      next_taken = 1'b0;
      next_accum = accum;
      next_index = index;
      next_result = operand;
      next_ccr = ccr_in;
      sum9 = 9'h000;
      low5 = 5'h00;
      prod = 16'h0000;
      tbit = operand[opcode[3:1]];
      case (hi)
         // Register/memory family: six modes share length and timing
         `COD_HI_IMM, `COD_HI_DIR, `COD_HI_EXT,
         `COD_HI_IX2, `COD_HI_IX1, `COD_HI_IX: begin
            case (hi)
               `COD_HI_IMM: begin
                  next_mode = `COD_M_IMM;
                  next_bytes = 2'h2;
                  next_cycles = 4'h2;
               end
               `COD_HI_DIR: begin
                  next_mode = `COD_M_DIR;
                  next_bytes = 2'h2;
                  next_cycles = 4'h3;
               end
               `COD_HI_EXT: begin
                  next_mode = `COD_M_EXT;
                  next_bytes = 2'h3;
                  next_cycles = 4'h4;
               end
               `COD_HI_IX: begin
                  next_mode = `COD_M_IX;
                  next_bytes = 2'h1;
                  next_cycles = 4'h3;
               end
               `COD_HI_IX1: begin
                  next_mode = `COD_M_IX1;
                  next_bytes = 2'h2;
                  next_cycles = 4'h4;
               end
               default: begin
                  next_mode = `COD_M_IX2;
                  next_bytes = 2'h3;
                  next_cycles = 4'h5;
               end
            endcase
            case (lo)
               `COD_LO_ADC: begin // [RULE_04]
                  low5 = {1'b0, accum[3:0]} + {1'b0, operand[3:0]}
                     + {4'h0, c_in};
                  sum9 = {1'b0, accum} + {1'b0, operand} + {8'h00, c_in};
                  next_accum = sum9[7:0];
                  next_ccr[`COD_H] = low5[4];
                  next_ccr[`COD_C] = sum9[8];
               end
               `COD_LO_BORROW_SUB: begin // [RULE_05]
                  sum9 = {1'b0, accum} - {1'b0, operand} - {8'h00, c_in};
                  next_accum = sum9[7:0];
                  next_ccr[`COD_C] = sum9[8];
               end
               `COD_LO_XOR: begin // [RULE_06]
                  sum9 = {1'b0, accum ^ operand};
                  next_accum = sum9[7:0];
               end
               `COD_LO_COMPARE: begin // [RULE_07]
                  sum9 = {1'b0, accum} - {1'b0, operand};
                  next_ccr[`COD_C] = sum9[8];
               end
               `COD_LO_BIT: begin // [RULE_08]
                  sum9 = {1'b0, accum & operand};
               end
               default: next_known = 1'b0;
            endcase
            next_result = sum9[7:0];
            next_ccr[`COD_N] = sum9[7];
            next_ccr[`COD_Z] = (sum9[7:0] == 8'h00);
         end
         // Read/modify/write family
         `COD_HI_INHA, `COD_HI_INHX, `COD_HI_DIRRMW,
         `COD_HI_IXRMW, `COD_HI_IX1RMW: begin
            case (hi)
               `COD_HI_INHA: begin
                  next_mode = `COD_M_INHA;
                  next_bytes = 2'h1;
                  next_cycles = 4'h3;
               end
               `COD_HI_INHX: begin
                  next_mode = `COD_M_INHX;
                  next_bytes = 2'h1;
                  next_cycles = 4'h3;
               end
               `COD_HI_DIRRMW: begin
                  next_mode = `COD_M_DIR;
                  next_bytes = 2'h2;
                  next_cycles = (lo == `COD_LO_PROBE) ? 4'h4 : 4'h5;
               end
               `COD_HI_IXRMW: begin
                  next_mode = `COD_M_IX;
                  next_bytes = 2'h1;
                  next_cycles = (lo == `COD_LO_PROBE) ? 4'h4 : 4'h5;
               end
               default: begin
                  next_mode = `COD_M_IX1;
                  next_bytes = 2'h2;
                  next_cycles = (lo == `COD_LO_PROBE) ? 4'h5 : 4'h6;
               end
            endcase
            // Register modes take their operand from the register itself
            if (hi == `COD_HI_INHA)
               sum9 = {1'b0, accum};
            else if (hi == `COD_HI_INHX)
               sum9 = {1'b0, index};
            else
               sum9 = {1'b0, operand};
            if (lo == `COD_LO_ROTATE) begin // [RULE_17]
               sum9 = {sum9[7:0], c_in};
               next_result = sum9[7:0];
               next_ccr[`COD_C] = sum9[8];
               next_wb = 1'b1; // [RULE_01]
               if (hi == `COD_HI_INHA)
                  next_accum = sum9[7:0];
               if (hi == `COD_HI_INHX)
                  next_index = sum9[7:0];
               next_ccr[`COD_N] = sum9[7];
               next_ccr[`COD_Z] = (sum9[7:0] == 8'h00);
            end else if (lo == `COD_LO_PROBE) begin // [RULE_16]
               // Flags only; location stays as it was
               next_wb = 1'b0; // [RULE_02]
               next_result = sum9[7:0];
               next_ccr[`COD_N] = sum9[7];
               next_ccr[`COD_Z] = (sum9[7:0] == 8'h00);
            end else if (hi == `COD_HI_INHA && lo == `COD_LO_PRODUCT) begin
               prod = {8'h00, index} * {8'h00, accum}; // [RULE_03]
               next_mode = `COD_M_INH;
               next_cycles = `COD_CYC_PRODUCT;
               next_index = prod[15:8];
               next_accum = prod[7:0];
               next_result = prod[7:0];
               next_ccr[`COD_H] = 1'b0; // [RULE_14]
               next_ccr[`COD_C] = 1'b0;
            end else begin
               next_known = 1'b0;
            end
         end
         // Relative branches, never a write
         `COD_HI_REL: begin
            next_mode = `COD_M_REL;
            next_bytes = 2'h2; // [RULE_15]
            next_cycles = `COD_CYC_REL;
            next_taken = base_cond ^ opcode[0]; // [RULE_15]
         end
         // Bit test and branch: even sets, odd clear, bit into carry
         `COD_HI_BTB: begin
            next_mode = `COD_M_BTB;
            next_bytes = 2'h3; // [RULE_18]
            next_cycles = `COD_CYC_BTB;
            next_ccr[`COD_C] = tbit; // [RULE_18]
            next_taken = tbit ^ opcode[0];
         end
         default: next_known = 1'b0;
      endcase
      // Unknown opcodes report nothing and change nothing
      if (!next_known) begin
         next_mode = `COD_M_NONE;
         next_bytes = 2'h0;
         next_cycles = 4'h0;
         next_wb = 1'b0;
         next_taken = 1'b0;
         next_accum = accum;
         next_index = index;
         next_result = operand;
         next_ccr = ccr_in;
      end
   end

   // Answer register; outputs other than dec_done hold until the next request
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         dec_done <= 1'b0;
         known <= 1'b0;
         mode <= `COD_M_NONE;
         instr_bytes <= 2'h0;
         instr_cycles <= 4'h0;
         write_back <= 1'b0;
         branch_taken <= 1'b0;
         accum_out <= 8'h00;
         index_out <= 8'h00;
         result_out <= 8'h00;
         ccr_out <= `COD_CCR_RST;
      end else begin
         dec_done <= dec_valid;
         if (dec_valid) begin
            known <= next_known;
            mode <= next_mode;
            instr_bytes <= next_bytes;
            instr_cycles <= next_cycles;
            write_back <= next_wb;
            branch_taken <= next_taken;
            accum_out <= next_accum;
            index_out <= next_index;
            result_out <= next_result;
            ccr_out <= next_ccr;
         end
      end
   end

endmodule

`default_nettype wire

// ==== verification/cod_decoder_chk.sv ====
// Port checker for the opcode decoder, bound to its instance.
// Assumes each answer lands one cycle after its request.
`timescale 1ns/100ps
`default_nettype none
module cod_decoder_chk (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Request
   input wire logic dec_valid,
   input wire logic [7:0] opcode,
   input wire logic [7:0] accum,
   input wire logic [7:0] index,
   input wire logic [7:0] operand,
   input wire logic [4:0] ccr_in,
   // Answer
   input wire logic dec_done,
   input wire logic [3:0] mode,
   input wire logic [1:0] instr_bytes,
   input wire logic [3:0] instr_cycles,
   input wire logic write_back,
   input wire logic branch_taken,
   input wire logic [7:0] accum_out,
   input wire logic [7:0] index_out,
   input wire logic [7:0] result_out,
   input wire logic [4:0] ccr_out
);
   logic [7:0] p_op, p_a, p_x, p_m;
   logic [4:0] p_c;
   wire logic am = opcode[7:4] >= 4'ha;
   default clocking
      @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   // Last request, kept so the answer can be judged without $past
   always_ff @(posedge ref_clk) begin
      p_op <= opcode;
      p_a <= accum;
      p_x <= index;
      p_m <= operand;
      p_c <= ccr_in;
   end
   AST_DONE: assert property (dec_valid |=> dec_done)
      else $error("request without answer");
   AST_PRODUCT: assert property (dec_valid && opcode == 8'h42 |=>
      {index_out, accum_out} == {8'h00, p_x} * {8'h00, p_a} &&
      instr_cycles == 4'hb && ccr_out == {1'b0, p_c[3:1], 1'b0})
      else $error("product wrong");
   AST_PROBE: assert property (dec_valid &&
      opcode[3:0] == 4'hd && opcode[7:4] inside {[4'h3:4'h7]} |=>
      !write_back)
      else $error("probe wrote back");
   AST_COMPARE: assert property (dec_valid && am &&
      (opcode[3:0] == 4'h1 || opcode[3:0] == 4'h5) |=>
      accum_out == p_a && !write_back)
      else $error("compare altered accumulator");
   AST_XOR: assert property (dec_valid && am &&
      opcode[3:0] == 4'h8 |=> accum_out == (p_a ^ p_m))
      else $error("xor result wrong");
   AST_REL: assert property (dec_valid && opcode[7:4] == 4'h2 |=>
      mode == 4'h8 && instr_bytes == 2'h2 && instr_cycles == 4'h3)
      else $error("branch length wrong");
   AST_BRF: assert property (dec_valid &&
      opcode inside {8'h24, 8'h25, 8'h28, 8'h29, 8'h2c, 8'h2d} |=>
      branch_taken == (p_op[0] ==
      (p_op[3] ? (p_op[2] ? p_c[3] : p_c[4]) : p_c[0])))
      else $error("flag branch wrong");
   AST_BTB: assert property (dec_valid && opcode[7:4] == 4'h0 |=>
      instr_bytes == 2'h3 && instr_cycles == 4'h5 &&
      ccr_out[0] == p_m[p_op[3:1]] &&
      branch_taken == (p_m[p_op[3:1]] ^ p_op[0]))
      else $error("bit test branch wrong");
   AST_ROTATE: assert property (dec_valid &&
      opcode inside {8'h39, 8'h69, 8'h79} |=> write_back &&
      result_out == {p_m[6:0], p_c[0]} && ccr_out[0] == p_m[7])
      else $error("rotate wrong");
   COV_PRODUCT: cover property (dec_valid && opcode == 8'h42);
   COV_BTB: cover property (dec_valid && opcode[7:4] == 4'h0);
   COV_TAKEN: cover property (dec_done && branch_taken);
endmodule
bind cod_decoder cod_decoder_chk chk_u (.ref_clk, .rst_b, .dec_valid,
   .opcode, .accum, .index, .operand, .ccr_in, .dec_done, .mode,
   .instr_bytes, .instr_cycles, .write_back, .branch_taken, .accum_out,
   .index_out, .result_out, .ccr_out);
`default_nettype wire

// ==== verification/cod_mem_model.sv ====
// One-byte data memory standing behind the decoder's operand input.
// Assumes the bench preloads it before each group of memory-mode requests.
`timescale 1ns/100ps
`default_nettype none
module cod_mem_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Bench preload
   input wire logic ld,
   input wire logic [7:0] din,
   // Decoder answer
   input wire logic dec_done,
   input wire logic write_back,
   input wire logic [7:0] result_out,
   // Read data
   output logic [7:0] operand
);
   // Stores only on bench preload or write-back, so a stray write shows up
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         operand <= 8'h00;
      end else if (ld) begin
         operand <= din;
      end else if (dec_done && write_back) begin
         operand <= result_out;
      end
   end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Bench for the opcode decoder: one request at a time, answers judged.
// Assumes the memory model feeds operand and takes written results.
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic ref_clk, rst_b, dec_valid, irq_pin, ld, dec_done;
   logic write_back, branch_taken, known;
   logic [7:0] opcode, accum, index, din, operand;
   logic [7:0] accum_out, index_out, result_out;
   logic [4:0] ccr_in, ccr_out;
   logic [3:0] instr_cycles, mode;
   logic [1:0] instr_bytes;
   int failures, n_checks;
   // Mode tables, first mode in the top nibble
   localparam logic [23:0] HI = 24'habcfed;
   localparam logic [23:0] BY = 24'h223123;
   localparam logic [23:0] CY = 24'h234345;
   localparam logic [19:0] RH = 20'h45376;
   localparam logic [19:0] RB = 20'h11212;
   localparam logic [19:0] TC = 20'h33445;
   localparam logic [19:0] LC = 20'h33556;
   localparam logic [63:0] BR = 64'h2223242528292c2d;
   // Memory byte for the bit tests, mixed ones and zeros
   localparam logic [7:0] BM = 8'h5a;

   cod_decoder dut_u (.ref_clk, .rst_b, .dec_valid, .opcode, .accum,
      .index, .operand, .ccr_in, .irq_pin, .dec_done, .known, .mode,
      .instr_bytes, .instr_cycles, .write_back, .branch_taken,
      .accum_out, .index_out, .result_out, .ccr_out);
   cod_mem_model mem_u (.ref_clk, .rst_b, .ld, .din, .dec_done,
      .write_back, .result_out, .operand);

   // 40 MHz clock
   always #12.5 ref_clk = ~ref_clk;

   task automatic chk(input logic [15:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic load(input logic [7:0] v);
      din <= v;
      ld <= 1'b1;
      @(posedge ref_clk);
      ld <= 1'b0;
   endtask

   // One request; the answer is awaited for a few cycles only
   task automatic op(input logic [7:0] o, a, x, input logic [4:0] c);
      int k;
      opcode <= o;
      accum <= a;
      index <= x;
      ccr_in <= c;
      dec_valid <= 1'b1;
      @(posedge ref_clk);
      dec_valid <= 1'b0;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (dec_done !== 1'b1 && k < 4);
      if (dec_done !== 1'b1) begin
         failures++;
         finish_test();
      end
   endtask

   // All six operand modes of one accumulator family
   task automatic modes(input logic [3:0] lo, input logic [7:0] a, m, e,
                        input logic [4:0] c);
      load(m);
      for (int i = 0; i < 6; i++) begin
         op({HI[4*(5-i)+:4], lo}, a, 8'h00, c);
         chk(instr_bytes, BY[4*(5-i)+:2]);
         chk({known, mode}, {1'b1, 4'(i)});
         chk(instr_cycles, CY[4*(5-i)+:4]);
         chk(accum_out, e);
      end
   endtask

   task automatic t_accum;
      modes(4'h9, 8'h0f, 8'h01, 8'h11, 5'h01);
      chk(ccr_out, 5'h10);
      modes(4'h2, 8'h10, 8'h01, 8'h0e, 5'h01);
      modes(4'h8, 8'ha5, 8'h0f, 8'haa, 5'h00);
      modes(4'h1, 8'h10, 8'h20, 8'h10, 5'h00);
      chk({write_back, ccr_out[0]}, 2'b01);
      modes(4'h5, 8'hf0, 8'h0f, 8'hf0, 5'h00);
      chk({write_back, ccr_out[1]}, 2'b01);
      // Undecoded operation in the immediate family: nothing reported or changed
      op(8'ha3, 8'h33, 8'h44, 5'h15);
      chk({known, mode, instr_bytes, instr_cycles, write_back,
           branch_taken}, {1'b0, 4'hf, 8'h00});
      chk({accum_out, index_out}, 16'h3344);
      chk(ccr_out, 5'h15);
   endtask

   task automatic t_product;
      op(8'h42, 8'hff, 8'hff, 5'h1f);
      chk({index_out, accum_out}, 16'hfe01);
      chk(instr_cycles, 4'hb);
      chk(ccr_out, 5'h0e);
   endtask

   // Probe must leave memory alone; rotate must write it back
   task automatic t_rmw;
      for (int i = 0; i < 5; i++) begin
         int s;
         s = 4 * (4 - i);
         load(8'h80);
         op({RH[s+:4], 4'hd}, 8'h80, 8'h80, 5'h00);
         chk(instr_cycles, TC[s+:4]);
         chk({write_back, ccr_out[2]}, 2'b01);
         @(posedge ref_clk);
         chk(operand, 8'h80);
         op({RH[s+:4], 4'h9}, 8'h80, 8'h80, 5'h01);
         chk({instr_bytes, instr_cycles}, {RB[s+:2], LC[s+:4]});
         chk({write_back, ccr_out[0]}, 2'b11);
         @(posedge ref_clk);
         if (i > 1) chk(operand, 8'h01);
         else chk(i ? index_out : accum_out, 8'h01);
      end
   endtask

   // Flags all clear, then all set: even codes taken first
   task automatic t_branch;
      for (int c = 0; c < 2; c++) begin
         for (int i = 0; i < 8; i++) begin
            op(BR[8*(7-i)+:8], 8'h00, 8'h00, c ? 5'h1f : 5'h00);
            chk(branch_taken, BR[8*(7-i)] == c[0]);
            chk({instr_bytes, instr_cycles}, 6'h23);
         end
      end
   endtask

   // Pin level is synchronised, so give it time to settle
   task automatic t_pin;
      for (int v = 0; v < 2; v++) begin
         irq_pin <= v[0];
         repeat (6) @(posedge ref_clk);
         op(8'h2e, 8'h00, 8'h00, 5'h00);
         chk(branch_taken, !v[0]);
         op(8'h2f, 8'h00, 8'h00, 5'h00);
         chk(branch_taken, v[0]);
      end
   endtask

   task automatic t_btb;
      load(BM);
      for (int i = 0; i < 16; i++) begin
         op(8'(i), 8'h00, 8'h00, 5'h00);
         chk({branch_taken, ccr_out[0]},
             {BM[i>>1] ^ i[0], BM[i>>1]});
         chk({instr_bytes, instr_cycles}, 6'h35);
      end
   endtask

   initial begin
      ref_clk = 1'b0;
      rst_b = 1'b0;
      {dec_valid, ld, irq_pin} = 3'b001;
      {opcode, accum, index, din} = 32'h0;
      ccr_in = 5'h00;
      failures = 0;
      n_checks = 0;
      repeat (12) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_accum();
      t_product();
      t_rmw();
      t_branch();
      t_pin();
      t_btb();
      finish_test();
   end
endmodule
`default_nettype wire
